// >>> logic/frs_consts.vh
// constants for the two-wire ferroelectric memory slave port
`ifndef FRS_CONSTS_VH
`define FRS_CONSTS_VH

// array geometry
`define FRS_ADDR_W 15
`define FRS_DATA_W 8
`define FRS_DEPTH 32768
`define FRS_ADDR_ZERO 15'h0000
`define FRS_ADDR_TOP 15'h7fff

// slave address byte fields
`define FRS_DEV_TYPE 4'ha
`define FRS_TYPE_HI 7
`define FRS_TYPE_LO 4
`define FRS_SEL_HI 3
`define FRS_SEL_LO 1
`define FRS_RW_BIT 0
`define FRS_HS_CODE 5'h01

// bit counter values
`define FRS_BITS_PER_BYTE 4'h8
`define FRS_CNT_ZERO 4'h0

// bus rates in kHz and the system clock in kHz
`define FRS_STD_KHZ 100
`define FRS_FAST_KHZ 400
`define FRS_HS_KHZ 3400
`define FRS_MCLK_KHZ 100000
// system clocks per fastest scl period, rounded down
`define FRS_HS_CYCLES (`FRS_MCLK_KHZ / `FRS_HS_KHZ)

// arbitrary neutral identification value: maker, density, revision
`define FRS_ID_DEFAULT 24'h0000_01

`endif

// >>> logic/frs_mem.v
// byte array with one write port and a registered read port
`timescale 1ns/100ps
`include "frs_consts.vh"
module frs_mem #(
	parameter AW = `FRS_ADDR_W,
	parameter DW = `FRS_DATA_W,
	parameter DEPTH = `FRS_DEPTH
) (
	input wire clk_in,
	input wire we_in,
	input wire [AW-1:0] waddr_in,
	input wire [DW-1:0] wdata_in,
	input wire [AW-1:0] raddr_in,
	output reg [DW-1:0] rdata_out
);
	reg [DW-1:0] mem [0:DEPTH-1];

	// write on strobe, read data registered every cycle
	always @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
		rdata_out <= mem[raddr_in];
	end
endmodule

// >>> logic/frs_port.v
// two-wire slave port in front of the byte array
`timescale 1ns/100ps
`include "frs_consts.vh"
module frs_port #(
	parameter [23:0] ID_VALUE = `FRS_ID_DEFAULT
) (
	input wire MCLK_IN,
	input wire SRST_IN,
	input wire SCL_IN,
	input wire SDA_IN,
	output reg SDA_OUT,
	output reg SDA_OE_N_OUT,
	input wire [2:0] DEVICE_SELECT_PINS_IN,
	input wire WP_IN,
	output reg HS_MODE_OUT,
	output reg [23:0] DEVICE_ID_OUT
);
	// protocol states
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_DEV = 3'h1;
	localparam [2:0] ST_AHI = 3'h2;
	localparam [2:0] ST_ALO = 3'h3;
	localparam [2:0] ST_WR = 3'h4;
	localparam [2:0] ST_RD = 3'h5;

	// synchroniser stages
	reg scl_s1_q;
	reg scl_s2_q;
	reg sda_s1_q;
	reg sda_s2_q;
	reg wp_s1_q;
	reg wp_s2_q;
	reg [2:0] sel_s1_q;
	reg [2:0] sel_s2_q;
	reg scl_prev_q;
	reg sda_prev_q;

	// protocol state
	reg [2:0] st_q;
	reg [3:0] cnt_q;
	reg in_ack_q;
	reg nack_q;
	reg [7:0] rx_q;
	reg [7:0] tx_q;
	reg [`FRS_ADDR_W-1:0] addr_q;
	reg sda_low_q;
	reg hs_q;

	// write strobe towards the array
	reg we_q;
	reg [`FRS_ADDR_W-1:0] waddr_q;
	reg [7:0] wdata_q;
	wire [7:0] rdata;

	// bus events
	wire scl_rise;
	wire scl_fall;
	wire start_ev;
	wire stop_ev;
	wire byte_done;
	wire ack_end;

	// next address with wrap from the top location to zero
	function [`FRS_ADDR_W-1:0] next_addr;
		input [`FRS_ADDR_W-1:0] a;
		begin
			if (a == `FRS_ADDR_TOP) begin
				next_addr = `FRS_ADDR_ZERO;
			end else begin
				next_addr = a + 15'h0001;
			end
		end
	endfunction

	// does a slave address byte name this device
	function addr_match;
		input [7:0] b;
		input [2:0] sel;
		begin
			addr_match = (b[`FRS_TYPE_HI:`FRS_TYPE_LO] == `FRS_DEV_TYPE)
				&& (b[`FRS_SEL_HI:`FRS_SEL_LO] == sel);
		end
	endfunction

	// two flip-flop synchronisers for all pins
	always @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			wp_s1_q <= 1'b0;
			wp_s2_q <= 1'b0;
			sel_s1_q <= 3'h0;
			sel_s2_q <= 3'h0;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_s1_q <= SCL_IN;
			scl_s2_q <= scl_s1_q;
			sda_s1_q <= SDA_IN;
			sda_s2_q <= sda_s1_q;
			wp_s1_q <= WP_IN;
			wp_s2_q <= wp_s1_q;
			sel_s1_q <= DEVICE_SELECT_PINS_IN;
			sel_s2_q <= sel_s1_q;
			scl_prev_q <= scl_s2_q;
			sda_prev_q <= sda_s2_q;
		end
	end

	// edge and condition detection on the synchronised lines
	assign scl_rise = scl_s2_q & ~scl_prev_q;
	assign scl_fall = ~scl_s2_q & scl_prev_q;
	assign start_ev = scl_s2_q & scl_prev_q & sda_prev_q & ~sda_s2_q;
	assign stop_ev = scl_s2_q & scl_prev_q & ~sda_prev_q & sda_s2_q;
	assign byte_done = scl_fall & ~in_ack_q & (cnt_q == `FRS_BITS_PER_BYTE);
	assign ack_end = scl_fall & in_ack_q;

	// bit counter, receive shifter and acknowledge sampling
	always @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			cnt_q <= `FRS_CNT_ZERO;
			rx_q <= 8'h00;
			nack_q <= 1'b0;
		end else if (start_ev || stop_ev) begin
			cnt_q <= `FRS_CNT_ZERO;
			nack_q <= 1'b0;
		end else if (scl_rise && st_q != ST_IDLE) begin
			if (in_ack_q) begin
				nack_q <= sda_s2_q;
			end else if (cnt_q != `FRS_BITS_PER_BYTE) begin
				rx_q <= {rx_q[6:0], sda_s2_q};
				cnt_q <= cnt_q + 4'h1;
			end
		end else if (ack_end) begin
			cnt_q <= `FRS_CNT_ZERO;
		end
	end

	// protocol state machine, address latch and sda drive
	always @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			st_q <= ST_IDLE;
			in_ack_q <= 1'b0;
			addr_q <= `FRS_ADDR_ZERO;
			tx_q <= 8'h00;
			sda_low_q <= 1'b0;
			hs_q <= 1'b0;
		end else if (stop_ev) begin
			st_q <= ST_IDLE;
			in_ack_q <= 1'b0;
			sda_low_q <= 1'b0;
			hs_q <= 1'b0;
		end else if (start_ev) begin
			st_q <= ST_DEV;
			in_ack_q <= 1'b0;
			sda_low_q <= 1'b0;
		end else if (byte_done) begin
			in_ack_q <= 1'b1;
			case (st_q)
				ST_DEV: begin
					if (rx_q[7:3] == `FRS_HS_CODE) begin
						hs_q <= 1'b1;
						st_q <= ST_IDLE;
					end else if (addr_match(rx_q, sel_s2_q)) begin
						sda_low_q <= 1'b1;
						if (rx_q[`FRS_RW_BIT]) begin
							st_q <= ST_RD;
						end else begin
							st_q <= ST_AHI;
						end
					end else begin
						st_q <= ST_IDLE;
					end
				end
				ST_AHI: begin
					addr_q[14:8] <= rx_q[6:0];
					sda_low_q <= 1'b1;
					st_q <= ST_ALO;
				end
				ST_ALO: begin
					addr_q[7:0] <= rx_q;
					sda_low_q <= 1'b1;
					st_q <= ST_WR;
				end
				ST_WR: begin
					addr_q <= next_addr(addr_q);
					sda_low_q <= 1'b1;
				end
				ST_RD: begin
					addr_q <= next_addr(addr_q);
					sda_low_q <= 1'b0;
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end else if (ack_end) begin
			in_ack_q <= 1'b0;
			if (st_q == ST_RD && !nack_q) begin
				tx_q <= {rdata[6:0], 1'b0};
				sda_low_q <= ~rdata[7];
			end else if (st_q == ST_RD) begin
				sda_low_q <= 1'b0;
				st_q <= ST_IDLE;
			end else begin
				sda_low_q <= 1'b0;
			end
		end else if (scl_fall && st_q == ST_RD) begin
			tx_q <= {tx_q[6:0], 1'b0};
			sda_low_q <= ~tx_q[7];
		end
	end

	// array write strobe, one cycle after the byte completes
	always @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			we_q <= 1'b0;
			waddr_q <= `FRS_ADDR_ZERO;
			wdata_q <= 8'h00;
		end else begin
			we_q <= byte_done && st_q == ST_WR && !wp_s2_q;
			waddr_q <= addr_q;
			wdata_q <= rx_q;
		end
	end

	// the array; writes finish in one cycle so no busy phase exists
	frs_mem #(
		.AW(`FRS_ADDR_W),
		.DW(`FRS_DATA_W),
		.DEPTH(`FRS_DEPTH)
	) u_mem (
		.clk_in(MCLK_IN),
		.we_in(we_q),
		.waddr_in(waddr_q),
		.wdata_in(wdata_q),
		.raddr_in(addr_q),
		.rdata_out(rdata)
	);

	// pin and status outputs; sda is open drain, data always low
	always @(posedge MCLK_IN) begin
		if (SRST_IN) begin
			SDA_OUT <= 1'b0;
			SDA_OE_N_OUT <= 1'b1;
			HS_MODE_OUT <= 1'b0;
			DEVICE_ID_OUT <= `FRS_ID_DEFAULT;
		end else begin
			SDA_OUT <= 1'b0;
			SDA_OE_N_OUT <= ~sda_low_q;
			HS_MODE_OUT <= hs_q;
			DEVICE_ID_OUT <= ID_VALUE;
		end
	end
endmodule

// >>> tb/frs_port_assertions.sv
// concurrent checks on the two-wire memory slave port
`timescale 1ns/100ps
module frs_chk (
	input MCLK_IN,
	input SRST_IN,
	input SCL_IN,
	input SDA_IN,
	input SDA_OUT,
	input SDA_OE_N_OUT,
	input [2:0] DEVICE_SELECT_PINS_IN,
	input WP_IN,
	input HS_MODE_OUT,
	input [23:0] DEVICE_ID_OUT
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (SRST_IN);
	// stop: sda rises while scl stays high
	sequence s_stop;
		SCL_IN && $past(SCL_IN) && $rose(SDA_IN);
	endsequence
	a_sda_zero: assert property (SDA_OUT == 1'b0)
		else $error("sda driven high");
	a_id_fixed: assert property (!$past(SRST_IN) |->
		$stable(DEVICE_ID_OUT)) else $error("id changed");
	a_oe_on_fall: assert property ($changed(SDA_OE_N_OUT) |->
		!SCL_IN && !$past(SCL_IN, 3)) else $error("sda moved late");
	a_low_stands: assert property ($fell(SDA_OE_N_OUT) |->
		!SDA_OE_N_OUT [*8]) else $error("low bit too short");
	a_stop_frees: assert property (s_stop |->
		##[1:8] SDA_OE_N_OUT) else $error("sda held after stop");
	a_hs_stop: assert property (s_stop |->
		##[1:8] !HS_MODE_OUT) else $error("hs kept after stop");
	a_hs_silent: assert property ($rose(HS_MODE_OUT) |->
		SDA_OE_N_OUT) else $error("master code acked");
	a_idle_reset: assert property ($past(SRST_IN) |->
		SDA_OE_N_OUT && !HS_MODE_OUT) else $error("busy after reset");
	c_ack: cover property ($fell(SDA_OE_N_OUT));
	c_hs: cover property ($rose(HS_MODE_OUT));
	c_stop: cover property (s_stop);
endmodule

bind frs_port frs_chk u_chk (.MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN),
	.SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
	.SDA_OE_N_OUT(SDA_OE_N_OUT), .WP_IN(WP_IN),
	.DEVICE_SELECT_PINS_IN(DEVICE_SELECT_PINS_IN),
	.HS_MODE_OUT(HS_MODE_OUT), .DEVICE_ID_OUT(DEVICE_ID_OUT));

// >>> tb/frs_port_tb.sv
// self-checking bench for the two-wire memory slave port
`timescale 1ns/100ps
`include "frs_consts.vh"
module frs_port_tb;
	reg clk = 1'b0;
	reg srst = 1'b1;
	reg wp = 1'b0;
	reg [2:0] pins = 3'b101;
	wire scl, sda_m, sdo, oe_n, hs, sda;
	wire [23:0] dev_id;
	integer err_count = 0;
	integer tests_run = 0;
	integer cyc = 0;
	reg [8:0] q;
	// wire-and of both parties; the pull-up wins when released
	assign sda = sda_m & (oe_n | sdo);
	initial forever #5 clk = ~clk;
	frs_port u_dut (.MCLK_IN(clk), .SRST_IN(srst), .SCL_IN(scl),
		.SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE_N_OUT(oe_n),
		.DEVICE_SELECT_PINS_IN(pins), .WP_IN(wp), .HS_MODE_OUT(hs),
		.DEVICE_ID_OUT(dev_id));
	frsm_master u_m (.sda_in(sda), .scl_out(scl), .sda_out(sda_m));
	// compare and count
	task chk(input string n, input [7:0] e, input [7:0] g);
		begin
			tests_run++;
			if (g !== e) begin
				err_count++;
				$display("[FAIL] %s exp %h got %h", n, e, g);
			end
		end
	endtask
	// byte out, acknowledge judged (0 = acked)
	task wb(input [7:0] b, input ea);
		begin
			u_m.xfer({b, 1'b1}, q);
			chk("ack", {7'h00, ea}, {7'h00, q[0]});
		end
	endtask
	// byte in; last leaves the slot released
	task rb(input [7:0] e, input last);
		begin
			u_m.xfer({8'hff, last}, q);
			chk("rdata", e, q[8:1]);
		end
	endtask
	// start, write select byte, both address bytes
	task at(input [2:0] s, input [14:0] a);
		begin
			u_m.start;
			wb({4'ha, s, 1'b0}, 1'b0);
			wb({1'b0, a[14:8]}, 1'b0);
			wb(a[7:0], 1'b0);
		end
	endtask
	// write over the top location, read back across the wrap
	task t_wrap;
		begin
			at(3'b101, 15'h7fff);
			wb(8'h5a, 1'b0);
			wb(8'hc3, 1'b0);
			u_m.stop;
			at(3'b101, 15'h7fff);
			u_m.start;
			wb(8'hab, 1'b0);
			rb(8'h5a, 1'b0);
			rb(8'hc3, 1'b1);
			u_m.stop;
		end
	endtask
	// protected write is acked but leaves the byte alone
	task t_protect;
		begin
			wp = 1'b1;
			at(3'b101, 15'h7fff);
			wb(8'h00, 1'b0);
			u_m.stop;
			wp = 1'b0;
			at(3'b101, 15'h7fff);
			u_m.start;
			wb(8'hab, 1'b0);
			rb(8'h5a, 1'b1);
			u_m.stop;
		end
	endtask
	// wrong select bits, wrong type, then all-zero pins
	task t_select;
		begin
			u_m.start;
			wb(8'ha2, 1'b1);
			u_m.start;
			wb(8'hba, 1'b1);
			u_m.stop;
			pins = 3'b000;
			at(3'b000, 15'h0000);
			u_m.stop;
			pins = 3'b101;
		end
	endtask
	// master code is not acked and sets high speed until stop
	task t_hs;
		begin
			u_m.start;
			wb(8'h09, 1'b1);
			chk("hs", 8'h01, {7'h00, hs});
			u_m.stop;
			#100;
			chk("hs", 8'h00, {7'h00, hs});
		end
	endtask
	// identification value stays fixed whatever the bus has written
	task t_id;
		reg [23:0] e;
		begin
			e = `FRS_ID_DEFAULT;
			chk("id_hi", e[23:16], dev_id[23:16]);
			chk("id_mid", e[15:8], dev_id[15:8]);
			chk("id_lo", e[7:0], dev_id[7:0]);
		end
	endtask
	// counts and verdict
	task conclude;
		begin
			$display("checks %0d mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	// reset, then the scenarios
	initial begin
		repeat (2) @(posedge clk);
		#1 srst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		t_id;
		t_wrap;
		t_protect;
		t_select;
		t_hs;
		t_id;
		conclude;
	end
	// cycle ceiling against a hung run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			conclude;
		end
	end
endmodule

// >>> tb/frsm_master.sv
// two-wire bus master on the port's far side
`timescale 1ns/100ps
module frsm_master (
	input sda_in,
	output reg scl_out,
	output reg sda_out
);
	// clock stands high and data is released outside frames
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// start or repeated start: sda falls while scl high
	task start;
		begin
			sda_out = 1'b1;
			#40 scl_out = 1'b1;
			#40 sda_out = 1'b0;
			#40 scl_out = 1'b0;
			#40;
		end
	endtask
	// stop: sda rises while scl high; no busy wait after it
	task stop;
		begin
			sda_out = 1'b0;
			#40 scl_out = 1'b1;
			#40 sda_out = 1'b1;
			#40;
		end
	endtask
	// nine clocks msb first; data changes only while scl is low
	task xfer(input [8:0] d, output [8:0] q);
		integer i;
		begin
			for (i = 8; i >= 0; i = i - 1) begin
				sda_out = d[i];
				#40 scl_out = 1'b1;
				#40 q[i] = sda_in;
				#40 scl_out = 1'b0;
				#40;
			end
		end
	endtask
endmodule
